//--- logic/clock_check_cfg.svh
// Purpose: Offsets, field positions, reset values and counts of the
//          transmit clock check.
// Assumes: Included by its bare name from the design files.
// Notes:   Definitions only.
`ifndef CLOCK_CHECK_CFG_SVH
`define CLOCK_CHECK_CFG_SVH

// Register byte addresses
`define CC_STATUS_OFFSET      12'h0c0
`define CC_INT_ENABLE_OFFSET  12'h0bc
`define CC_CONTROL_OFFSET     12'h0c8
`define CC_ADDR_WIDTH         12

// Control register field positions
`define CC_COUNT_LSB          24
`define CC_COUNT_MSB          31
`define CC_UPPER_LSB          16
`define CC_UPPER_MSB          23
`define CC_LOWER_LSB          8
`define CC_LOWER_MSB          15
`define CC_AUTOSW_BIT         7
`define CC_RSVD_LSB           4
`define CC_RSVD_MSB           6
`define CC_PRESCALE_LSB       0
`define CC_PRESCALE_MSB       3

// Status and interrupt enable field position
`define CC_FAIL_BIT           2

// Reset values
`define CC_CONTROL_RESET      32'h0000_0000
`define CC_COUNT_RESET        8'h00
`define CC_BOUND_RESET        8'h00
`define CC_PRESCALE_RESET     4'h0
`define CC_READ_ZERO          32'h0000_0000

// Measurement window and prescaler limits
`define CC_WINDOW_EDGES       32
`define CC_WINDOW_LAST        5'h1f
`define CC_PRESCALE_MAX_CODE  4'h8
`define CC_COUNT_SATURATE     8'hff

`endif

//--- logic/clock_check_pkg.sv
// Purpose: Types shared by the transmit clock check modules.
// Assumes: Nothing beyond the cfg header.
// Notes:   Types only; numbers live in clock_check_cfg.svh.
package clock_check_pkg;

   typedef logic [7:0]  count_t;
   typedef logic [3:0]  prescale_t;
   typedef logic [4:0]  edge_count_t;

   typedef enum logic [1:0] {
      reg_none,
      reg_control,
      reg_status,
      reg_int_enable
   } reg_sel_t;

endpackage

//--- logic/meter_if.sv
// Purpose: Carries prescale setting and window results between modules.
// Assumes: One system clock domain.
// Notes:   window_done is a one-cycle pulse with window_count valid.
`timescale 1ns/1ps
interface meter_if;
   import clock_check_pkg::*;

   prescale_t prescale_select;
   logic      window_done;
   count_t    window_count;

   modport meter (
      input  prescale_select,
      output window_done,
      output window_count
   );

   modport ctrl (
      output prescale_select,
      input  window_done,
      input  window_count
   );
endinterface

//--- logic/clock_meter.sv
// Purpose: Counts prescaled system clocks per 32 master clock edges.
// Assumes: Master clock below half the system clock rate.
// Notes:   Count saturates at all ones so slow master clocks still fail high.
`timescale 1ns/1ps
`include "clock_check_cfg.svh"
module clock_meter
   import clock_check_pkg::*;
(
   input  wire logic clk,
   input  wire logic resetn,
   input  wire logic master_clock,
   meter_if.meter    m
);

   logic        mclk_meta;
   logic        mclk_sync;
   logic        mclk_prev;
   logic        mclk_edge;
   logic [7:0]  div_cnt;
   logic        tick;
   edge_count_t edge_cnt;
   count_t      sys_cnt;
   count_t      next_sys_cnt;
   logic        window_end;

   // Divide code to a mask of low divider bits; reserved codes use /256
   function automatic logic [7:0] prescale_mask(input prescale_t sel);
      logic [7:0] mask;
      mask = 8'hff;
      if (sel <= `CC_PRESCALE_MAX_CODE) begin
         mask = 8'((9'h001 << sel) - 9'h001);
      end
      return mask;
   endfunction

   // Two flops before any logic looks at the pin
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         mclk_meta <= 1'b0;
         mclk_sync <= 1'b0;
         mclk_prev <= 1'b0;
      end else begin
         mclk_meta <= master_clock;
         mclk_sync <= mclk_meta;
         mclk_prev <= mclk_sync;
      end
   end

   assign mclk_edge = mclk_sync & ~mclk_prev;

   // Free-running divider feeding the check counter
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         div_cnt <= 8'h00;
      end else begin
         div_cnt <= div_cnt + 8'h01;
      end
   end

   assign tick = (div_cnt & prescale_mask(m.prescale_select)) ==
                 prescale_mask(m.prescale_select);

   assign window_end = mclk_edge && (edge_cnt == `CC_WINDOW_LAST);

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         edge_cnt <= 5'h00;
      end else if (mclk_edge) begin
         edge_cnt <= edge_cnt + 5'h01;
      end
   end

   always_comb begin
      next_sys_cnt = sys_cnt;
      if (tick && sys_cnt != `CC_COUNT_SATURATE) begin
         next_sys_cnt = sys_cnt + 8'h01;
      end
   end

   // Result taken and counter restarted only at a full window
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sys_cnt        <= `CC_COUNT_RESET;
         m.window_count <= `CC_COUNT_RESET;
         m.window_done  <= 1'b0;
      end else begin
         m.window_done <= window_end;
         if (window_end) begin
            m.window_count <= next_sys_cnt;
            sys_cnt        <= `CC_COUNT_RESET;
         end else begin
            sys_cnt <= next_sys_cnt;
         end
      end
   end

endmodule // clock_meter

//--- logic/transmit_clock_check.sv
// Purpose: APB register front end and failure logic of the transmit
//          clock check.
// Assumes: APB master per the published protocol; one system clock.
// Notes:   Every access completes with no wait cycle; unmapped addresses error.
`timescale 1ns/1ps
`include "clock_check_cfg.svh"
module transmit_clock_check
   import clock_check_pkg::*;
(
   input  wire logic                      clk,
   input  wire logic                      resetn,
   input  wire logic [`CC_ADDR_WIDTH-1:0] paddr,
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [31:0]               pwdata,
   input  wire logic [3:0]                pstrb,
   output logic [31:0]                    prdata,
   output logic                           pready,
   output logic                           pslverr,
   input  wire logic                      tx_high_freq_master_clock,
   output logic                           failure_autoswitch_enable,
   output logic                           autoswitch_request,
   output logic                           transmit_interrupt
);

   meter_if mif ();

   count_t      measured_clock_count;
   count_t      count_upper_bound;
   count_t      count_lower_bound;
   logic        autoswitch_en;
   prescale_t   check_prescaler_select;
   logic        tx_clock_failure_flag;
   logic        failure_int_enable;

   reg_sel_t    setup_sel;
   logic        setup;
   logic        access_done;
   logic        wr_commit;
   logic        wr_control;
   logic        wr_status;
   logic        wr_int_enable;
   logic        failure_event;
   logic        next_failure_flag;
   logic [31:0] control_word;
   logic [31:0] next_prdata;

   clock_meter meter (
      .clk          (clk),
      .resetn       (resetn),
      .master_clock (tx_high_freq_master_clock),
      .m            (mif.meter)
   );

   assign mif.prescale_select = check_prescaler_select;

   // Address decode, shared by read data and write strobes
   function automatic reg_sel_t decode(
      input logic [`CC_ADDR_WIDTH-1:0] addr
   );
      reg_sel_t sel;
      sel = reg_none;
      case (addr)
         `CC_CONTROL_OFFSET:    sel = reg_control;
         `CC_STATUS_OFFSET:     sel = reg_status;
         `CC_INT_ENABLE_OFFSET: sel = reg_int_enable;
         default:               sel = reg_none;
      endcase
      return sel;
   endfunction

   assign setup_sel   = decode(paddr);
   assign setup       = psel && !penable;
   assign access_done = psel && penable && pready;
   assign wr_commit   = access_done && pwrite && !pslverr;

   assign wr_control    = wr_commit && (decode(paddr) == reg_control);
   assign wr_status     = wr_commit && (decode(paddr) == reg_status);
   assign wr_int_enable = wr_commit && (decode(paddr) == reg_int_enable);

   // No wait cycle: ready rises in the first access cycle
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= setup;
         pslverr <= setup && (setup_sel == reg_none);
      end
   end

   always_comb begin
      control_word = `CC_READ_ZERO;
      control_word[`CC_COUNT_MSB:`CC_COUNT_LSB] = measured_clock_count;
      control_word[`CC_UPPER_MSB:`CC_UPPER_LSB] = count_upper_bound;
      control_word[`CC_LOWER_MSB:`CC_LOWER_LSB] = count_lower_bound;
      control_word[`CC_AUTOSW_BIT] = autoswitch_en;
      control_word[`CC_RSVD_MSB:`CC_RSVD_LSB] = 3'h0;
      control_word[`CC_PRESCALE_MSB:`CC_PRESCALE_LSB] =
         check_prescaler_select;
   end

   always_comb begin
      next_prdata = `CC_READ_ZERO;
      if (setup && !pwrite) begin
         case (setup_sel)
            reg_control: begin
               next_prdata = control_word;
            end
            reg_status: begin
               next_prdata[`CC_FAIL_BIT] = tx_clock_failure_flag;
            end
            reg_int_enable: begin
               next_prdata[`CC_FAIL_BIT] = failure_int_enable;
            end
            default: begin
               next_prdata = `CC_READ_ZERO;
            end
         endcase
      end
   end

   // Read data captured at setup, held through the access cycle
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         prdata <= `CC_READ_ZERO;
      end else if (setup) begin
         prdata <= next_prdata;
      end
   end

   // Writable control fields honour byte strobes; reserved bits dropped
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         count_upper_bound      <= `CC_BOUND_RESET;
         count_lower_bound      <= `CC_BOUND_RESET;
         autoswitch_en          <= 1'b0;
         check_prescaler_select <= `CC_PRESCALE_RESET;
      end else if (wr_control) begin
         if (pstrb[2]) begin
            count_upper_bound <=
               pwdata[`CC_UPPER_MSB:`CC_UPPER_LSB];
         end
         if (pstrb[1]) begin
            count_lower_bound <=
               pwdata[`CC_LOWER_MSB:`CC_LOWER_LSB];
         end
         if (pstrb[0]) begin
            autoswitch_en <= pwdata[`CC_AUTOSW_BIT];
            check_prescaler_select <=
               pwdata[`CC_PRESCALE_MSB:`CC_PRESCALE_LSB];
         end
      end
   end

   // Count field is read-only; only a finished window loads it
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         measured_clock_count <= `CC_COUNT_RESET;
      end else if (mif.window_done) begin
         measured_clock_count <= mif.window_count;
      end
   end

   // Unsigned compare of the fresh count against both bounds
   assign failure_event = mif.window_done &&
      ((mif.window_count > count_upper_bound) ||
       (mif.window_count < count_lower_bound));

   // Set beats a same-cycle write-one clear so no failure is lost
   always_comb begin
      next_failure_flag = tx_clock_failure_flag;
      if (wr_status && pstrb[0] && pwdata[`CC_FAIL_BIT]) begin
         next_failure_flag = 1'b0;
      end
      if (failure_event) begin
         next_failure_flag = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         tx_clock_failure_flag <= 1'b0;
      end else begin
         tx_clock_failure_flag <= next_failure_flag;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         failure_int_enable <= 1'b0;
      end else if (wr_int_enable && pstrb[0]) begin
         failure_int_enable <= pwdata[`CC_FAIL_BIT];
      end
   end

   // Outputs straight from flops; one cycle after the flag and autoswitch_en they follow
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         transmit_interrupt        <= 1'b0;
         failure_autoswitch_enable <= 1'b0;
         autoswitch_request        <= 1'b0;
      end else begin
         transmit_interrupt <= tx_clock_failure_flag &&
                               failure_int_enable;
         failure_autoswitch_enable <= autoswitch_en;
         autoswitch_request <= tx_clock_failure_flag &&
                               autoswitch_en;
      end
   end

endmodule // transmit_clock_check

//--- tb/clock_check_properties.sv
// Purpose: Port assertions of the transmit clock check.
// Assumes: One clock; APB answer one cycle after setup.
// Notes:   Window bounds allow for the sync and load delay.
`timescale 1ns/1ps
`include "clock_check_cfg.svh"
module clock_check_props (
   input wire logic                      clk,
   input wire logic                      resetn,
   input wire logic [`CC_ADDR_WIDTH-1:0] paddr,
   input wire logic                      psel,
   input wire logic                      penable,
   input wire logic                      pwrite,
   input wire logic [31:0]               pwdata,
   input wire logic [3:0]                pstrb,
   input wire logic [31:0]               prdata,
   input wire logic                      pready,
   input wire logic                      pslverr,
   input wire logic                      tx_high_freq_master_clock,
   input wire logic                      failure_autoswitch_enable,
   input wire logic                      autoswitch_request,
   input wire logic                      transmit_interrupt
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   logic       commit, ctl_wr, sw_exp, mclk_q;
   logic [3:0] since_edge, since_wr;
   assign commit = psel && penable && pready && !pslverr;
   assign ctl_wr = commit && pwrite && pstrb[0]
                   && paddr == `CC_CONTROL_OFFSET;
   // Saturating ages let a flag rise be tied to its cause
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sw_exp     <= 1'b0;
         mclk_q     <= 1'b0;
         since_edge <= 4'hf;
         since_wr   <= 4'hf;
      end else begin
         mclk_q <= tx_high_freq_master_clock;
         if (ctl_wr) sw_exp <= pwdata[7];
         if (tx_high_freq_master_clock && !mclk_q) since_edge <= 4'h0;
         else if (since_edge != 4'hf) since_edge <= since_edge + 4'h1;
         if (commit && pwrite) since_wr <= 4'h0;
         else if (since_wr != 4'hf) since_wr <= since_wr + 4'h1;
      end
   end
   a_ready_after_setup: assert property (psel && !penable |=> pready)
      else $error("pready missing after setup");
   a_ready_single: assert property (pready |=> !pready)
      else $error("pready held too long");
   a_error_in_access: assert property (pslverr |-> pready && penable)
      else $error("pslverr outside access");
   a_unmapped_error: assert property (psel && !penable |=> pslverr ==
      !(paddr inside {`CC_STATUS_OFFSET, `CC_INT_ENABLE_OFFSET,
      `CC_CONTROL_OFFSET}))
      else $error("pslverr wrong for address");
   a_reserved_read_zero: assert property (
      pready && !pwrite && paddr == `CC_CONTROL_OFFSET |-> prdata[6:4] == 3'h0)
      else $error("reserved bits read nonzero");
   a_autosw_tracks_write: assert property (
      ctl_wr |-> ##[1:2] failure_autoswitch_enable == sw_exp)
      else $error("autoswitch enable not written");
   a_request_needs_enable: assert property (
      !failure_autoswitch_enable && !$past(failure_autoswitch_enable)
      && !$past(failure_autoswitch_enable, 2) |-> !autoswitch_request)
      else $error("autoswitch request while disabled");
   a_reset_outputs_low: assert property ($rose(resetn) |->
      !transmit_interrupt && !autoswitch_request && !failure_autoswitch_enable)
      else $error("outputs not clear after reset");
   a_flag_at_window: assert property ($rose(transmit_interrupt) |->
      since_edge <= 4'ha || since_wr <= 4'h3)
      else $error("interrupt rose away from a window end");
endmodule // clock_check_props

bind transmit_clock_check clock_check_props u_props (
   .clk(clk), .resetn(resetn), .paddr(paddr), .psel(psel),
   .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
   .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .tx_high_freq_master_clock(tx_high_freq_master_clock),
   .failure_autoswitch_enable(failure_autoswitch_enable),
   .autoswitch_request(autoswitch_request),
   .transmit_interrupt(transmit_interrupt));

//--- tb/master_clock_source.sv
// Purpose: Free running transmit master clock source.
// Assumes: Half period in whole ns, well above two system clocks.
// Notes:   Holds its level while stopped, as a gated source would.
`timescale 1ns/1ps
module master_clock_source (
   input wire logic run,
   input int        half_ns,
   output logic     mclk
);
   // Half-ns phase keeps every toggle away from the system clock edges
   initial begin
      mclk = 1'b0;
      #0.5;
      forever begin
         if (run) #(half_ns) mclk = ~mclk;
         else #1;
      end
   end
endmodule // master_clock_source

//--- tb/tb_top.sv
// Purpose: Scenario testbench of the transmit clock check.
// Assumes: 40 ns master period, so a window is 320 system clocks.
// Notes:   Counts allow one tick of slack for the free divider phase.
`timescale 1ns/1ps
`include "clock_check_cfg.svh"
module tb_top;
   logic        clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic        pwrite = 1'b0, run = 1'b0, pready, pslverr, mclk;
   logic        sw_en, sw_req, irq, err;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, q;
   logic [3:0]  pstrb = 4'h0;
   int          num_errors = 0, samples_checked = 0;
   always #2 clk = ~clk;
   master_clock_source src (.run(run), .half_ns(20), .mclk(mclk));
   transmit_clock_check dut (.clk(clk), .resetn(resetn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .tx_high_freq_master_clock(mclk), .failure_autoswitch_enable(sw_en),
      .autoswitch_request(sw_req), .transmit_interrupt(irq));
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] s);
      samples_checked++;
      if (s !== e) begin
         num_errors++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask
   // Request held until pready is seen high at a rising edge
   task automatic apb(input logic [11:0] a, input logic w,
                      input logic [31:0] d);
      int n = 0;
      paddr <= a; pwrite <= w; pwdata <= d; pstrb <= 4'hf; psel <= 1'b1;
      @(posedge clk) penable <= 1'b1;
      do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 50);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) chk("pready", 1, 0);
      @(posedge clk);
   endtask
   // Two full windows so the count reflects the present setting
   task automatic windows();
      repeat (700) @(posedge clk);
   endtask
   task automatic t_reset();
      apb(`CC_CONTROL_OFFSET, 0, 0);
      chk("control reset", 32'h0000_0000, q);
      apb(`CC_STATUS_OFFSET, 0, 0);
      chk("status reset", 32'h0000_0000, q);
   endtask
   task automatic t_fields();
      apb(`CC_CONTROL_OFFSET, 1, 32'hffff_fff3);
      apb(`CC_CONTROL_OFFSET, 0, 0);
      chk("control fields", 32'h00ff_ff83, q);
      chk("autoswitch out", 1, sw_en);
      apb(12'h0f0, 1, 32'hffff_ffff);
      chk("unmapped error", 1, err);
   endtask
   task automatic t_prescale();
      int e;
      run <= 1'b1;
      // Reserved code 9 divides by 256 like the top legal code
      for (int c = 0; c <= 9; c++) begin
         apb(`CC_CONTROL_OFFSET, 1, {24'h00ff_00, 4'h0, c[3:0]});
         windows();
         apb(`CC_CONTROL_OFFSET, 0, 0);
         chk("prescale field", c, q[3:0]);
         e = (c == 0) ? 255 : (320 >> ((c > 8) ? 8 : c));
         chk("count", 1, q[31:24] >= e - 1 && q[31:24] <= e + 1);
      end
   endtask
   task automatic t_bounds();
      apb(`CC_INT_ENABLE_OFFSET, 1, 32'h0000_0004);
      apb(`CC_CONTROL_OFFSET, 1, 32'h005a_4602);
      windows();
      apb(`CC_STATUS_OFFSET, 1, 32'h0000_0004);
      windows();
      apb(`CC_STATUS_OFFSET, 0, 0);
      chk("flag in bounds", 0, q[2]);
      apb(`CC_CONTROL_OFFSET, 1, 32'h003c_0002);
      windows();
      apb(`CC_STATUS_OFFSET, 0, 0);
      chk("flag above max", 1, q[2]);
      chk("interrupt", 1, irq);
      apb(`CC_CONTROL_OFFSET, 1, 32'h00ff_0002);
      windows();
      apb(`CC_STATUS_OFFSET, 1, 0);
      apb(`CC_STATUS_OFFSET, 0, 0);
      chk("write zero kept", 1, q[2]);
      apb(`CC_STATUS_OFFSET, 1, 32'h0000_0004);
      apb(`CC_STATUS_OFFSET, 0, 0);
      chk("write one clears", 0, q[2]);
      // A signed compare would take 0xc8 as negative and not fail on the lower bound
      apb(`CC_CONTROL_OFFSET, 1, 32'h00ff_c882);
      windows();
      apb(`CC_STATUS_OFFSET, 0, 0);
      chk("flag below min", 1, q[2]);
      chk("autoswitch request", 1, sw_req);
      apb(`CC_CONTROL_OFFSET, 1, 32'h00ff_c802);
      repeat (4) @(posedge clk);
      chk("request disabled", 0, sw_req);
   endtask
   task automatic conclude();
      $display("Checks %0d, errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      t_reset();
      t_fields();
      t_prescale();
      t_bounds();
      conclude();
   end
   initial begin
      #100_000;
      num_errors++;
      conclude();
   end
endmodule // tb_top
